// ==== azs_sequencer.sv ====
// Auto-zero sequencer: switch and host start, attempts, averaging, LEDs
//
// Functional notes
// - Retry unstable attempt, four attempts at most
// - Alternate red/green flash after failed attempt, not the fourth
// - Switch start: final zero is average of attempts
// - Store zero, keep it until next zeroing
// - Stable only when signal stays within band
// - Held switch: red pulse, green at 8-12 s
// - Fast green blink while zeroing, about 60 s
// - Success: measured reads zero, green steady
// - Digital: wait stable, else take nearest zero
// - Digital done restores previous setpoint source
`timescale 1ns/10ps
module azs_sequencer
  import azs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,  // Cycles per millisecond tick
  parameter int SMP_LOG     = 8          // Log2 of samples per attempt
) (
  input  wire logic               ref_clk_i,
  input  wire logic               nrst_i,
  input  wire logic               sw_press_n_i,   // Push switch pin
  input  wire logic               sample_vld_i,
  input  wire logic signed [15:0] sample_i,       // Raw sensor value
  input  wire azs_req_t           req_i,
  output logic             [31:0] rdata_o,
  output logic                    red_o,
  output logic                    green_o,
  output logic                    irq_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (TICK_CYCLES < 1) begin : g_chk_tick
    $error("TICK_CYCLES must be at least 1");
  end
  if (SMP_LOG < 1 || SMP_LOG > 12) begin : g_chk_smp
    $error("SMP_LOG must lie in 1..12");
  end

  localparam int TW = $clog2(TICK_CYCLES + 1);  // Never zero wide, even at one cycle per tick
  localparam int SW = 16 + SMP_LOG;

  azs_state_t                  state_r, state_nxt;
  azs_seq_t                    seq_r;
  logic        [TW-1:0]        tick_r;
  logic        [15:0]          timer_r, ph_r;
  logic                        tog_r, sw_meta_r, sw_sync_r, dig_r;
  logic        [2:0]           att_r;
  logic        [SMP_LOG:0]     smp_r;
  logic signed [SW-1:0]        sum_r;
  logic signed [15:0]          min_r, max_r, best_r, final_r, meas_r;
  logic signed [17:0]          acc_r;
  logic        [7:0]           unlock_r, src_r, cal_r, src_save_r;
  logic        [15:0]          band_r, zero_w;
  logic        [IRQ_W-1:0]     ist_r, ien_r;

  // ----------------------------------------------------------------
  // Switch synchroniser and millisecond tick
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sw_meta_r <= 1'b1;
      sw_sync_r <= 1'b1;
      tick_r    <= '0;
    end else begin
      sw_meta_r <= sw_press_n_i;
      sw_sync_r <= sw_meta_r;
      tick_r    <= (tick_r == TW'(TICK_CYCLES - 1)) ? '0 : tick_r + 1'b1;
    end
  end

  wire pressed_w = ~sw_sync_r;
  wire tick_w    = (tick_r == TW'(TICK_CYCLES - 1));

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire       wr_w      = req_i.wr;
  wire [7:0] wd8_w     = req_i.wdata[7:0];
  wire       wr_unlk_w = wr_w && (req_i.addr == OFF_INIT_UNLOCK);
  wire       wr_src_w  = wr_w && (req_i.addr == OFF_SETPT_SRC);
  wire       wr_cal_w  = wr_w && (req_i.addr == OFF_CAL_SEQ);
  wire       wr_band_w = wr_w && (req_i.addr == OFF_NOISE_BAND);
  wire       wr_ien_w  = wr_w && (req_i.addr == OFF_IRQ_EN);
  wire       wr_iclr_w = wr_w && (req_i.addr == OFF_IRQ_CLR);

  // Host start sequence: exact order, any stray value restarts it
  wire seq_go_w = wr_cal_w && (seq_r == SEQ_CLR) && (wd8_w == CAL_GO_VAL);
  azs_seq_t seq_nxt;
  always_comb begin
    seq_nxt = seq_r;
    if (wr_unlk_w) begin
      seq_nxt = (wd8_w == UNLOCK_VAL) ? SEQ_UNLK : SEQ_NONE;
    end else if (wr_src_w) begin
      seq_nxt = (seq_r == SEQ_UNLK && wd8_w == SRC_ZERO_VAL) ? SEQ_SRC : SEQ_NONE;
    end else if (wr_cal_w) begin
      case (seq_r)
        SEQ_SRC: seq_nxt = (wd8_w == CAL_ARM_VAL) ? SEQ_ARM : SEQ_NONE;
        SEQ_ARM: seq_nxt = (wd8_w == CAL_CLR_VAL) ? SEQ_CLR : SEQ_NONE;
        default: seq_nxt = SEQ_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Attempt evaluation
  // ----------------------------------------------------------------
  wire                     smp_full_w = smp_r[SMP_LOG];
  wire signed [SW-1:0]     sum_sh_w   = sum_r >>> SMP_LOG;
  wire signed [15:0]       mean_w     = sum_sh_w[15:0];
  wire signed [16:0]       span_w     = 17'(max_r) - 17'(min_r);
  wire                     stable_w   = smp_full_w && (span_w <= $signed({1'b0, band_r}));
  wire [2:0]               cnt_w      = att_r + 3'd1;
  wire signed [17:0]       acc_nxt_w  = acc_r + 18'(mean_w);
  wire att_end_w  = (state_r == AZS_MEAS) && tick_w && (timer_r == ATTEMPT_MS - 16'd1);
  wire flash_end_w = (state_r == AZS_FLASH) && tick_w && (timer_r == FLASH_MS - 16'd1);
  wire retry_w    = !stable_w && (cnt_w < MAX_ATTEMPTS);
  wire fail_ev_w  = att_end_w && !stable_w;
  wire closer_w   = (att_r == 3'd0) || (azs_abs(mean_w) < azs_abs(best_r));
  wire signed [15:0] best_nxt_w = closer_w ? mean_w : best_r;

  // Average over 1..4 attempts; thirds by scaled multiply
  wire signed [35:0] third_w = acc_nxt_w * 18'sd21846;
  logic signed [15:0] avg_w;
  always_comb begin
    case (cnt_w)
      3'd1:    avg_w = acc_nxt_w[15:0];
      3'd2:    avg_w = acc_nxt_w[16:1];
      3'd3:    avg_w = third_w[31:16];
      default: avg_w = acc_nxt_w[17:2];
    endcase
  end

  // Host start: stable mean, else nearest zero; switch start: average
  wire signed [15:0] final_nxt_w = dig_r ? (stable_w ? mean_w : best_nxt_w)
                                         : avg_w;

  // ----------------------------------------------------------------
  // Sequence state machine
  // ----------------------------------------------------------------
  wire in_window_w = (timer_r >= GREEN_MIN_MS) && (timer_r < GREEN_MAX_MS);
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      AZS_IDLE: begin
        if (pressed_w) begin
          state_nxt = AZS_HOLD;
        end else if (seq_go_w) begin
          state_nxt = AZS_MEAS;
        end
      end
      AZS_HOLD: begin
        if (!pressed_w) begin
          state_nxt = in_window_w ? AZS_MEAS : AZS_IDLE;
        end
      end
      AZS_MEAS: begin
        if (att_end_w) begin
          state_nxt = (retry_w && !(dig_r && stable_w)) ? AZS_FLASH : AZS_STORE;
        end
      end
      AZS_FLASH: begin
        if (flash_end_w) begin
          state_nxt = AZS_MEAS;
        end
      end
      AZS_STORE: state_nxt = AZS_IDLE;
      default:   state_nxt = AZS_IDLE;
    endcase
  end

  wire new_state_w = (state_nxt != state_r);
  wire start_ev_w  = new_state_w && (state_nxt == AZS_MEAS) && (state_r != AZS_FLASH);
  wire store_w     = (state_r == AZS_STORE);

  // State, phase timer and blink toggle
  wire [15:0] half_w = (state_r == AZS_FLASH) ? FLASH_HALF_MS : BLINK_HALF_MS;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= AZS_IDLE;
      timer_r <= '0;
      ph_r    <= '0;
      tog_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      timer_r <= new_state_w ? 16'd0 : (tick_w ? timer_r + 16'd1 : timer_r);
      if (new_state_w || (tick_w && ph_r == half_w - 16'd1)) begin
        ph_r  <= '0;
        tog_r <= new_state_w ? 1'b0 : ~tog_r;
      end else if (tick_w) begin
        ph_r  <= ph_r + 16'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample gathering and attempt bookkeeping
  // ----------------------------------------------------------------
  wire clr_att_w = new_state_w && (state_nxt == AZS_MEAS);
  wire take_w    = (state_r == AZS_MEAS) && sample_vld_i && !smp_full_w;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      smp_r <= '0;
      sum_r <= '0;
      min_r <= '0;
      max_r <= '0;
    end else if (clr_att_w) begin
      smp_r <= '0;
      sum_r <= '0;
    end else if (take_w) begin
      smp_r <= smp_r + 1'b1;
      sum_r <= sum_r + SW'(sample_i);
      min_r <= (smp_r == '0 || sample_i < min_r) ? sample_i : min_r;
      max_r <= (smp_r == '0 || sample_i > max_r) ? sample_i : max_r;
    end
  end

  // Attempt count, running sums; cleared at a fresh start only
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      att_r   <= '0;
      acc_r   <= '0;
      best_r  <= '0;
      final_r <= '0;
      dig_r   <= 1'b0;
    end else if (start_ev_w) begin
      att_r <= '0;
      acc_r <= '0;
      dig_r <= (state_r == AZS_IDLE);
    end else if (att_end_w) begin
      att_r   <= cnt_w;
      acc_r   <= acc_nxt_w;
      best_r  <= best_nxt_w;
      final_r <= final_nxt_w;
    end
  end

  // Zero kept in the store until the next completed procedure
  azs_nvm #(
    .W       (16),
    .RST_VAL (FACTORY_ZERO)
  ) u_nvm (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .we_i      (store_w),
    .wdata_i   (final_r),
    .rdata_o   (zero_w)
  );

  // ----------------------------------------------------------------
  // Host-visible parameters and measured value
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seq_r      <= SEQ_NONE;
      unlock_r   <= '0;
      src_r      <= SETPT_SRC_RST;
      src_save_r <= SETPT_SRC_RST;
      cal_r      <= '0;
      band_r     <= NOISE_BAND_RST;
      ien_r      <= '0;
      meas_r     <= '0;
    end else begin
      seq_r <= seq_nxt;
      if (wr_unlk_w) unlock_r <= wd8_w;
      if (wr_cal_w) cal_r <= wd8_w;
      if (wr_band_w) band_r <= req_i.wdata[15:0];
      if (wr_ien_w) ien_r <= req_i.wdata[IRQ_W-1:0];
      if (wr_src_w && seq_nxt == SEQ_SRC) src_save_r <= src_r;
      // Hardware restore wins over a host write in the same cycle
      if (store_w && dig_r) begin
        src_r <= src_save_r;
      end else if (wr_src_w) begin
        src_r <= wd8_w;
      end
      if (sample_vld_i) meas_r <= sample_i - $signed(zero_w);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, enable and clear
  // ----------------------------------------------------------------
  wire [IRQ_W-1:0] iev_w = {start_ev_w, fail_ev_w, store_w};
  wire [IRQ_W-1:0] iclr_w = wr_iclr_w ? req_i.wdata[IRQ_W-1:0] : '0;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ist_r <= '0;
      irq_o <= 1'b0;
    end else begin
      ist_r <= (ist_r & ~iclr_w) | iev_w;  // Set beats clear
      irq_o <= |(ist_r & ien_r);
    end
  end

  // ----------------------------------------------------------------
  // Read mux; data stand only in the cycle after the strobe
  // ----------------------------------------------------------------
  wire [31:0] status_w = {21'd0, state_r, 3'd0, (state_r != AZS_IDLE), dig_r, att_r};
  logic [31:0] rd_mux_w;
  always_comb begin
    case (req_i.addr)
      OFF_INIT_UNLOCK: rd_mux_w = {24'd0, unlock_r};
      OFF_SETPT_SRC:   rd_mux_w = {24'd0, src_r};
      OFF_CAL_SEQ:     rd_mux_w = {24'd0, cal_r};
      OFF_STATUS:      rd_mux_w = status_w;
      OFF_ZERO:        rd_mux_w = {16'd0, zero_w};
      OFF_MEAS:        rd_mux_w = {16'd0, meas_r};
      OFF_NOISE_BAND:  rd_mux_w = {16'd0, band_r};
      OFF_IRQ_STAT:    rd_mux_w = {29'd0, ist_r};
      OFF_IRQ_EN:      rd_mux_w = {29'd0, ien_r};
      default:         rd_mux_w = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // LED drive
  // ----------------------------------------------------------------
  logic red_nxt, green_nxt;
  always_comb begin
    case (state_r)
      AZS_HOLD: begin
        red_nxt   = (timer_r >= RED_ON_MS) && (timer_r < RED_OFF_MS);
        green_nxt = in_window_w;
      end
      AZS_MEAS: begin
        red_nxt   = 1'b0;
        green_nxt = tog_r;
      end
      AZS_FLASH: begin
        red_nxt   = tog_r;
        green_nxt = ~tog_r;
      end
      default: begin
        red_nxt   = 1'b0;
        green_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
      red_o   <= 1'b0;
      green_o <= 1'b0;
    end else begin
      rdata_o <= req_i.rd ? rd_mux_w : 32'h0000_0000;
      red_o   <= red_nxt;
      green_o <= green_nxt;
    end
  end

endmodule : azs_sequencer

// ==== azs_pkg.sv ====
// Constants, types and helpers shared by the auto-zero sequencer
package azs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS         = 1_000_000;
  localparam int TICK_CYC      = MS_NS / CLK_PERIOD_NS;  // Cycles per millisecond
  localparam logic [15:0] RED_ON_MS     = 16'd2000;  // Red pulse starts while held
  localparam logic [15:0] RED_OFF_MS    = 16'd4000;  // Red pulse ends
  localparam logic [15:0] GREEN_MIN_MS  = 16'd8000;  // Green on, release now starts zeroing
  localparam logic [15:0] GREEN_MAX_MS  = 16'd12000; // Release window closes
  localparam logic [15:0] ATTEMPT_MS    = 16'd15000; // One attempt, four fill about 60 s
  localparam logic [15:0] FLASH_MS      = 16'd3000;  // Alternating flash after a failure that is retried
  localparam logic [15:0] FLASH_HALF_MS = 16'd250;
  localparam logic [15:0] BLINK_HALF_MS = 16'd100;   // Fast green blink while zeroing
  localparam logic [2:0]  MAX_ATTEMPTS  = 3'd4;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_INIT_UNLOCK = 8'h00;
  localparam logic [7:0] OFF_SETPT_SRC   = 8'h04;
  localparam logic [7:0] OFF_CAL_SEQ     = 8'h08;
  localparam logic [7:0] OFF_STATUS      = 8'h0c;
  localparam logic [7:0] OFF_ZERO        = 8'h10;
  localparam logic [7:0] OFF_MEAS        = 8'h14;
  localparam logic [7:0] OFF_NOISE_BAND  = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT    = 8'h1c;
  localparam logic [7:0] OFF_IRQ_EN      = 8'h20;
  localparam logic [7:0] OFF_IRQ_CLR     = 8'h24;

  localparam logic [7:0]  UNLOCK_VAL     = 8'h40;  // 64
  localparam logic [7:0]  SRC_ZERO_VAL   = 8'h09;
  localparam logic [7:0]  CAL_ARM_VAL    = 8'hff;
  localparam logic [7:0]  CAL_CLR_VAL    = 8'h00;
  localparam logic [7:0]  CAL_GO_VAL     = 8'h09;
  localparam logic [7:0]  SETPT_SRC_RST  = 8'h00;
  localparam logic [15:0] NOISE_BAND_RST = 16'h0040;
  localparam logic [15:0] FACTORY_ZERO   = 16'h0000;

  localparam int IRQ_DONE  = 0;
  localparam int IRQ_FAIL  = 1;
  localparam int IRQ_START = 2;
  localparam int IRQ_W     = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AZS_IDLE  = 3'b000,
    AZS_HOLD  = 3'b001,
    AZS_MEAS  = 3'b011,
    AZS_STORE = 3'b010,
    AZS_FLASH = 3'b111
  } azs_state_t;

  typedef enum logic [2:0] {
    SEQ_NONE = 3'd0, SEQ_UNLK = 3'd1, SEQ_SRC = 3'd2, SEQ_ARM = 3'd3, SEQ_CLR = 3'd4
  } azs_seq_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } azs_req_t;

  // Magnitude of a signed zero value
  function automatic logic [15:0] azs_abs(input logic signed [15:0] v);
    azs_abs = v[15] ? 16'(-v) : 16'(v);
  endfunction : azs_abs

endpackage : azs_pkg

// ==== azs_nvm.sv ====
// Non-volatile zero store with registered read data
`timescale 1ns/10ps
module azs_nvm
  import azs_pkg::*;
#(
  parameter int          W       = 16,
  parameter logic [15:0] RST_VAL = FACTORY_ZERO
) (
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         we_i,
  input  wire logic [W-1:0] wdata_i,
  output logic      [W-1:0] rdata_o
);

  if (W < 1 || W > 16) begin : g_chk_w
    $error("W must lie in 1..16");
  end

  logic [W-1:0] mem_r;

  // ----------------------------------------------------------------
  // Storage; reset stands for the power-on load of the factory zero
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_r   <= RST_VAL[W-1:0];
      rdata_o <= RST_VAL[W-1:0];
    end else begin
      if (we_i) begin
        mem_r <= wdata_i;
      end
      rdata_o <= we_i ? wdata_i : mem_r;
    end
  end

endmodule : azs_nvm

// ==== azs_monitor.sv ====
// Port checker for the auto-zero sequencer
`timescale 1ns/10ps
module azs_monitor
  import azs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic        ref_clk_i,
  input wire logic        nrst_i,
  input wire logic        sw_press_n_i,
  input wire azs_req_t    req_i,
  input wire logic [31:0] rdata_o,
  input wire logic        red_o,
  input wire logic        green_o
);
  localparam int T = TICK_CYCLES;
  logic [31:0] hold_r;

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Cycles held low at the pin; margins cover the two-stage synchroniser
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) hold_r <= 32'h0;
    else hold_r <= sw_press_n_i ? 32'h0 : hold_r + 32'h1;
  end
  wire dark_w  = hold_r > 32'd10 && hold_r < 32'(7990 * T);
  wire red_w   = hold_r > 32'(2010 * T) && hold_r < 32'(3990 * T);
  wire ready_w = hold_r > 32'(8010 * T) && hold_r < 32'(11990 * T);

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_nb_wr;
    req_i.wr && req_i.addr == OFF_NOISE_BAND;
  endsequence
  sequence s_nb_rd;
    req_i.rd && req_i.addr == OFF_NOISE_BAND;
  endsequence
  sequence s_idle_lit;
    green_o && !red_o;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_NB_READBACK: assert property (s_nb_wr ##1 s_nb_rd |=>
    rdata_o == 32'($past(req_i.wdata[15:0], 2))) else $error("band readback wrong");
  AST_RD_STANDS: assert property (rdata_o != 32'h0 |-> $past(req_i.rd))
    else $error("read data outside its cycle");
  AST_RD_NOMAP: assert property (req_i.rd && req_i.addr >= OFF_IRQ_CLR |=> rdata_o == 32'h0)
    else $error("clear or unmapped read not zero");
  AST_RED_GREEN_EXCL: assert property (red_o |-> !green_o)
    else $error("red and green lit together");
  AST_RED_MIN: assert property ($rose(red_o) |-> red_o [*8])
    else $error("red pulse too short");
  AST_HOLD_DARK: assert property (dark_w |-> !green_o)
    else $error("green lit too early while held");
  AST_HOLD_RED: assert property (red_w |-> red_o)
    else $error("red pulse missing while held");
  AST_HOLD_GREEN: assert property (ready_w |-> green_o)
    else $error("green missing in release window");
  AST_EARLY_REL: assert property ($rose(sw_press_n_i) && dark_w |-> ##[1:8] s_idle_lit)
    else $error("early release did not return to idle");
endmodule : azs_monitor

bind azs_sequencer azs_monitor #(.TICK_CYCLES(TICK_CYCLES)) azs_monitor_i (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sw_press_n_i(sw_press_n_i), .req_i(req_i),
  .rdata_o(rdata_o), .red_o(red_o), .green_o(green_o));

// ==== azs_sensor_model.sv ====
// Sensor model: paced samples, steady or noisy around a base value
`timescale 1ns/10ps
module azs_sensor_model (
  input  wire logic               ref_clk_i,
  input  wire logic               nrst_i,
  input  wire logic               noisy_i,
  input  wire logic signed [15:0] base_i,
  output logic                    sample_vld_o,
  output logic signed [15:0]      sample_o
);
  logic [2:0] pace_r;
  logic       alt_r;
  wire        fire_w = pace_r == 3'h7;

  // One sample in eight cycles; noise swings 200 counts, far past the band.
  // Between samples the data toggles so stale values are never trusted.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pace_r       <= 3'h0;
      alt_r        <= 1'b0;
      sample_vld_o <= 1'b0;
      sample_o     <= 16'sh0;
    end else begin
      pace_r       <= pace_r + 3'h1;
      sample_vld_o <= fire_w;
      alt_r        <= fire_w ? ~alt_r : alt_r;
      sample_o     <= fire_w ? base_i + ((noisy_i && alt_r) ? 16'sd200 : 16'sd0) : ~sample_o;
    end
  end
endmodule : azs_sensor_model

// ==== tb_azs_sequencer.sv ====
// Self-checking bench for the auto-zero sequencer
`timescale 1ns/10ps
module tb_azs_sequencer;
  import azs_pkg::*;
  localparam int T = 1;
  logic               ref_clk_i, nrst_i, sw_press_n_i, sample_vld_i;
  logic               red_o, green_o, irq_o, noisy;
  logic signed [15:0] sample_i, base;
  logic signed [15:0] m [4];
  azs_req_t           req_i;
  logic        [31:0] rdata_o, d;
  logic        [7:0]  old_src;
  int                 err_count, cmp_count, n;

  azs_sequencer #(.TICK_CYCLES(T), .SMP_LOG(2)) azs_sequencer_i (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .sw_press_n_i(sw_press_n_i), .sample_vld_i(sample_vld_i),
    .sample_i(sample_i), .req_i(req_i), .rdata_o(rdata_o), .red_o(red_o),
    .green_o(green_o), .irq_o(irq_o));
  azs_sensor_model azs_sensor_model_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .noisy_i(noisy), .base_i(base), .sample_vld_o(sample_vld_i), .sample_o(sample_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------------------------------
  // Tasks and expectation helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic req(input logic [7:0] a, input logic [31:0] v, input logic w);
    @(posedge ref_clk_i);
    req_i <= '{addr: a, wdata: v, wr: w, rd: !w};
    @(posedge ref_clk_i);
    req_i <= '0;
    #1;
    d = rdata_o;
  endtask : req

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    req(a, 32'h0, 1'b0);
    chk(nm, d, e);
  endtask : rc

  // Poll the state code; bounded so a stuck sequence shows up as a mismatch
  task automatic wait_st(input logic [2:0] s);
    for (int i = 0; i < 40000; i++) begin
      req(OFF_STATUS, 32'h0, 1'b0);
      if (d[10:8] === s) break;
    end
    chk("state", 32'(d[10:8]), 32'(s));
  endtask : wait_st

  // Toggles of green (g=1) or red over a span of cycles
  task automatic edges(input int cyc, input bit g);
    logic p;
    n = 0;
    p = g ? green_o : red_o;
    repeat (cyc) begin
      @(posedge ref_clk_i);
      #1;
      if ((g ? green_o : red_o) !== p) n++;
      p = g ? green_o : red_o;
    end
  endtask : edges

  function automatic logic [31:0] nearest();
    logic signed [15:0] b;
    b = m[0];
    for (int k = 1; k < 4; k++)
      if ((m[k] < 0 ? -m[k] : m[k]) < (b < 0 ? -b : b)) b = m[k];
    return {16'h0, b};
  endfunction : nearest

  task automatic test_done();
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (130000) @(posedge ref_clk_i);
    err_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst_i = 1'b0;
    sw_press_n_i = 1'b1;
    req_i = '0;
    noisy = 1'b0;
    base = 16'sh0;
    err_count = 0;
    cmp_count = 0;
    void'($urandom(24440));
    repeat (8) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    // Reset values, decode, back-to-back band write then read
    rc("band", OFF_NOISE_BAND, 32'h40);
    rc("zero_rst", OFF_ZERO, 32'h0);
    rc("unmapped", 8'h30, 32'h0);
    d = $urandom;
    @(posedge ref_clk_i);
    req_i <= '{addr: OFF_NOISE_BAND, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    req_i <= '{addr: OFF_NOISE_BAND, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    req_i <= '0;
    #1;
    chk("band_rb", rdata_o, {16'h0, d[15:0]});
    req(OFF_NOISE_BAND, 32'h40, 1'b1);
    req(OFF_IRQ_EN, 32'h7, 1'b1);
    // Early release: red pulse shows, then idle with zero untouched
    sw_press_n_i <= 1'b0;
    repeat (2500 * T) @(posedge ref_clk_i);
    #1;
    chk("red_hold", 32'({red_o, green_o}), 32'h2);
    repeat (500 * T) @(posedge ref_clk_i);
    sw_press_n_i <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    rc("zero_kept", OFF_ZERO, 32'h0);
    rc("st_early", OFF_STATUS, 32'h0);
    // Switch start on a steady signal
    base <= 16'($urandom_range(0, 1000)) - 16'sd500;
    sw_press_n_i <= 1'b0;
    repeat (9000 * T) @(posedge ref_clk_i);
    #1;
    chk("green_ready", 32'({red_o, green_o}), 32'h1);
    sw_press_n_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    rc("busy", OFF_STATUS, 32'h310);
    chk("st_meas", 32'(d[10:8]), 32'h3);
    wait_st(3'b000);
    rc("zero_sw", OFF_ZERO, {16'h0, base});
    // Let one fresh sample meet the new zero
    repeat (8) @(posedge ref_clk_i);
    rc("meas0", OFF_MEAS, 32'h0);
    chk("green_steady", 32'(green_o), 32'h1);
    chk("irq_done", 32'(irq_o), 32'h1);
    req(OFF_IRQ_CLR, 32'h7, 1'b1);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("irq_clr", 32'(irq_o), 32'h0);
    // Host start, every attempt noisy
    old_src = 8'($urandom_range(0, 8));
    req(OFF_SETPT_SRC, 32'(old_src), 1'b1);
    noisy <= 1'b1;
    req(OFF_CAL_SEQ, 32'(CAL_GO_VAL), 1'b1);
    rc("lone_go", OFF_STATUS, 32'h1);
    for (int k = 0; k < 4; k++) m[k] = 16'($urandom_range(0, 2000)) - 16'sd900;
    base <= m[0] - 16'sd100;
    req(OFF_INIT_UNLOCK, 32'(UNLOCK_VAL), 1'b1);
    req(OFF_SETPT_SRC, 32'(SRC_ZERO_VAL), 1'b1);
    req(OFF_CAL_SEQ, 32'(CAL_ARM_VAL), 1'b1);
    req(OFF_CAL_SEQ, 32'(CAL_CLR_VAL), 1'b1);
    req(OFF_CAL_SEQ, 32'(CAL_GO_VAL), 1'b1);
    edges(1000, 1'b1);
    chk("blink", 32'(n inside {[9:11]}), 32'h1);
    for (int k = 0; k < 3; k++) begin
      wait_st(3'b111);
      chk("attempts", 32'(d[2:0]), 32'(k + 1));
      edges(1000, 1'b0);
      chk("flash", 32'(n inside {[3:5]}), 32'h1);
      base <= m[k + 1] - 16'sd100;
      wait_st(3'b011);
    end
    wait_st(3'b000);
    chk("attempts_max", 32'(d[2:0]), 32'h4);
    rc("zero_host", OFF_ZERO, nearest());
    rc("src_back", OFF_SETPT_SRC, 32'(old_src));
    rc("irq_stat", OFF_IRQ_STAT, 32'h7);
    req(OFF_IRQ_EN, 32'h0, 1'b1);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("irq_mask", 32'(irq_o), 32'h0);
    req(OFF_INIT_UNLOCK, 32'h0, 1'b1);
    rc("unlock", OFF_INIT_UNLOCK, 32'h0);
    test_done();
  end
endmodule : tb_azs_sequencer
